/* logic/smsp_pkg.sv */
// Summary of operation
// R1: Master, transfer-mode set: a transmit write starts a byte; interrupt on transmit empty.
// R2: Master, transfer-mode clear: a receive read starts a byte; interrupt on receive full.
// R3: Bit-order set shifts least significant bit first, clear shifts most significant first.
// R4: Polarity set rests the serial clock high, clear rests it low.
// R5: Phase set pulses the clock at bit start, clear pulses it at bit end.
// R6: Role bit set makes the port master driving the clock, clear makes it slave.
// R7: The port works only while its enable bit is set.
// R8: Overflow flag sets when a byte arrives over unread data; receive read clears it.
// R9: Receive interrupt bit follows receive-full or overflow; receive read clears it.
// R10: Receive-full flag marks a held byte; receive read clears it.
// R11: Underflow flag sets when a byte is needed but none written; transmit write clears.
// R12: Transmit interrupt bit follows not-occupied or underflow; write or finished disable clears.
// R13: Transmit-occupied sets on write, holds while shifting, clears once the register empties.
// R14: An 8-bit read/write divider register resets to 0x1B.
// R15: An 8-bit read-only receive register holds the last byte and resets to zero.
// R16: An 8-bit write-only transmit register loads the byte to shift out.
// R17: Master clock rate is the core clock over two times one plus divider.
// R18: As slave, a low select frames bytes until the select is released.
// R19: On overflow, overwrite bit set replaces the held byte, clear discards the new one.
// R20: On underflow, mode bit set resends the previous byte, clear sends zero.
// R21: Disabling returns the shifter to idle and rests the clock at its polarity.
package smsp_pkg;

	localparam logic [31:0] ADDR_STATUS = 32'hFFFF0A00;
	localparam logic [31:0] ADDR_RX = 32'hFFFF0A04;
	localparam logic [31:0] ADDR_TX = 32'hFFFF0A08;
	localparam logic [31:0] ADDR_DIV = 32'hFFFF0A0C;
	localparam logic [31:0] ADDR_CTRL = 32'hFFFF0A10;

	// Control field positions.
	localparam int CTL_EN = 0;
	localparam int CTL_MASTER = 1;
	localparam int CTL_CPHA = 2;
	localparam int CTL_CPOL = 3;
	localparam int CTL_LSBF = 5;
	localparam int CTL_TXMODE = 6;
	localparam int CTL_UFMODE = 7;
	localparam int CTL_OVW = 8;
	localparam logic [15:0] CTL_MASK = 16'h1FEF;

	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [7:0] DIV_RST = 8'h1B;
	localparam logic [7:0] RX_RST = 8'h00;
	localparam logic [3:0] LAST_BIT = 4'h7;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {SMSP_IDLE, SMSP_RUN} smsp_st_t;
	typedef enum logic [2:0] {REG_STA, REG_RX, REG_TX, REG_DIV, REG_CTL,
		REG_NONE} smsp_reg_t;

	typedef struct packed {
		logic sclk;
		logic mosi;
		logic miso;
		logic ss_n;
	} smsp_pin_in_t;

	typedef struct packed {
		logic sclk_o;
		logic sclk_oe_n;
		logic mosi_o;
		logic mosi_oe_n;
		logic miso_o;
		logic miso_oe_n;
	} smsp_pin_out_t;

	typedef struct packed {
		smsp_pin_in_t s1;
		smsp_pin_in_t s2;
		logic sclk_d;
		logic [15:0] ctrl;
		logic [7:0] div;
		logic [7:0] rx;
		logic [7:0] txd;
		logic [7:0] prev;
		logic tx_pend;
		logic tx_occ;
		logic uflow;
		logic tx_irq;
		logic rx_full;
		logic ovf;
		logic rx_irq;
		logic go;
		smsp_st_t st;
		logic [7:0] sh;
		logic [7:0] rsh;
		logic outb;
		logic [3:0] bits;
		logic [7:0] hcnt;
		logic sclk_q;
		logic aw_have;
		logic w_have;
		logic [31:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} smsp_state_t;

	localparam smsp_state_t STATE_RST = '{ctrl: CTRL_RST, div: DIV_RST,
		rx: RX_RST, st: SMSP_IDLE, s1: 4'hF, s2: 4'hF, default: '0};

endpackage : smsp_pkg

/* logic/smsp_port.sv */
`timescale 1ns/1ps
module smsp_port (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire smsp_pkg::smsp_pin_in_t pin_in,
	output smsp_pkg::smsp_pin_out_t pin_out,
	output logic spi_irq
);
	import smsp_pkg::*;

	smsp_state_t r;
	smsp_state_t n;
	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic do_wr;
	logic rd_rx;
	logic start;
	logic done;
	logic lead;
	logic trail;
	logic samp;
	logic shft;
	logic sin;
	logic en;
	logic master;
	logic cpol;
	logic cpha;
	logic lsbf;
	logic [7:0] rbyte;
	logic [7:0] lbyte;

	function automatic smsp_reg_t reg_sel(input logic [31:0] a);
		case (a)
			ADDR_STATUS: reg_sel = REG_STA;
			ADDR_RX: reg_sel = REG_RX;
			ADDR_TX: reg_sel = REG_TX;
			ADDR_DIV: reg_sel = REG_DIV;
			ADDR_CTRL: reg_sel = REG_CTL;
			default: reg_sel = REG_NONE;
		endcase
	endfunction : reg_sel

	function automatic logic fbit(input logic [7:0] b, input logic lsb);
		fbit = lsb ? b[0] : b[7];
	endfunction : fbit

	function automatic logic [7:0] shl(input logic [7:0] b, input logic lsb);
		shl = lsb ? {1'b0, b[7:1]} : {b[6:0], 1'b0};
	endfunction : shl

	function automatic logic [7:0] rin(input logic [7:0] b, input logic d,
		input logic lsb);
		rin = lsb ? {d, b[7:1]} : {b[6:0], d};
	endfunction : rin

	// Readies drop with the clock enable so no beat is taken while frozen.
	assign awready = ce && !r.aw_have && !r.bvalid;
	assign wready = ce && !r.w_have && !r.bvalid;
	assign arready = ce && !r.rvalid;
	assign aw_hs = awvalid && awready;
	assign w_hs = wvalid && wready;
	assign ar_hs = arvalid && arready;
	assign bvalid = r.bvalid;
	assign bresp = r.bresp;
	assign rvalid = r.rvalid;
	assign rresp = r.rresp;
	assign rdata = r.rdata;

	assign en = r.ctrl[CTL_EN];
	assign master = r.ctrl[CTL_MASTER];
	assign cpol = r.ctrl[CTL_CPOL];
	assign cpha = r.ctrl[CTL_CPHA];
	assign lsbf = r.ctrl[CTL_LSBF];

	// Pin drive; the clock rests at the polarity whenever idle.
	always_comb
	begin
		pin_out.sclk_o = (r.st == SMSP_RUN) ? r.sclk_q : cpol; // see R4
		pin_out.sclk_oe_n = !(en && master); // see R6
		pin_out.mosi_o = r.outb;
		pin_out.mosi_oe_n = !(en && master);
		pin_out.miso_o = r.outb;
		pin_out.miso_oe_n = !(en && !master && !r.s2.ss_n); // see R18
	end

	// Interrupt request follows the trigger mode in master operation.
	assign spi_irq = en && master &&
		(r.ctrl[CTL_TXMODE] ? r.tx_irq : r.rx_irq); // see R1 see R2

	// Whole next state: bus slave, flags and shift engine.
	always_comb
	begin
		n = r;
		start = 1'b0;
		done = 1'b0;
		lead = 1'b0;
		trail = 1'b0;
		rbyte = 8'h00;
		lbyte = 8'h00;
		rd_rx = 1'b0;
		sin = master ? r.s2.miso : r.s2.mosi;
		// Pins cross into this clock through two flops each.
		n.s1 = pin_in;
		n.s2 = r.s1;
		n.sclk_d = r.s2.sclk;

		// Read channel; the receive read is a side effect of the take.
		if (ar_hs)
		begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			n.rdata = 32'h00000000;
			unique case (reg_sel(araddr))
				REG_STA: n.rdata[7:0] = {2'b00, r.ovf, r.rx_irq, r.rx_full,
					r.uflow, r.tx_irq, r.tx_occ};
				REG_RX:
				begin
					n.rdata[7:0] = r.rx; // see R15
					rd_rx = 1'b1;
				end
				REG_TX: n.rdata = 32'h00000000;
				REG_DIV: n.rdata[7:0] = r.div;
				REG_CTL: n.rdata[15:0] = r.ctrl;
				REG_NONE: n.rresp = RESP_SLVERR;
			endcase
		end
		else if (r.rvalid && rready)
			n.rvalid = 1'b0;
		if (rd_rx)
		begin
			n.rx_full = 1'b0; // see R10
			n.ovf = 1'b0; // see R8
		end

		// Shift engine; disabling parks it at once.
		if (!en)
		begin
			n.st = SMSP_IDLE; // see R7 see R21
			n.sclk_q = cpol;
			n.hcnt = 8'h00;
			n.bits = 4'h0;
		end
		else
			unique case (r.st)
				SMSP_IDLE:
				begin
					n.sclk_q = cpol;
					n.hcnt = 8'h00;
					if (master)
						start = r.ctrl[CTL_TXMODE] ? r.tx_pend : // see R1
							(r.go || rd_rx); // see R2
					else
						start = !r.s2.ss_n; // see R18
				end
				SMSP_RUN:
					if (master)
					begin
						// Half period is one plus the divider core cycles.
						if (r.hcnt == r.div)
						begin
							n.hcnt = 8'h00; // see R17
							n.sclk_q = !r.sclk_q;
							lead = (r.sclk_q == cpol);
							trail = !lead;
						end
						else
							n.hcnt = r.hcnt + 8'h01;
					end
					else if (r.s2.ss_n)
						n.st = SMSP_IDLE; // see R18
					else if (r.s2.sclk != r.sclk_d)
					begin
						lead = (r.sclk_d == cpol);
						trail = !lead;
					end
			endcase

		// Phase picks which clock edge samples and which shifts.
		samp = cpha ? trail : lead; // see R5
		shft = cpha ? lead : (trail && r.bits != LAST_BIT);
		if (samp)
			n.rsh = rin(r.rsh, sin, lsbf);
		if (shft)
		begin
			n.outb = fbit(r.sh, lsbf); // see R3
			n.sh = shl(r.sh, lsbf);
		end
		if (trail)
		begin
			n.bits = r.bits + 4'h1;
			done = (r.bits == LAST_BIT);
		end

		// A finished byte lands in the receive register, unless it overflows with overwrite clear.
		if (done)
		begin
			n.bits = 4'h0;
			rbyte = cpha ? rin(r.rsh, sin, lsbf) : r.rsh;
			if (r.rx_full && !rd_rx)
			begin
				n.ovf = 1'b1; // see R8
				if (r.ctrl[CTL_OVW])
					n.rx = rbyte; // see R19
			end
			else
			begin
				n.rx = rbyte;
				n.rx_full = 1'b1; // see R10
			end
			if (!r.tx_pend)
				n.tx_occ = 1'b0; // see R13
			if (master)
				n.st = SMSP_IDLE;
			else
				start = 1'b1; // see R18
		end

		// Load the next byte, or the underflow filler.
		if (start)
		begin
			n.st = SMSP_RUN;
			n.bits = 4'h0;
			n.go = 1'b0;
			if (r.tx_pend)
			begin
				lbyte = r.txd;
				n.prev = r.txd;
				n.tx_pend = 1'b0;
			end
			else
			begin
				n.uflow = 1'b1; // see R11
				lbyte = r.ctrl[CTL_UFMODE] ? r.prev : 8'h00; // see R20
			end
			n.sh = lbyte;
			if (!cpha)
			begin
				n.outb = fbit(lbyte, lsbf); // see R3
				n.sh = shl(lbyte, lsbf);
			end
		end
		else if (rd_rx && en && master && !r.ctrl[CTL_TXMODE])
			n.go = 1'b1; // see R2

		// Write channel; a write beats a clear of occupied, an underflow
		// raised in the same cycle beats the write so software still sees it.
		if (aw_hs)
		begin
			n.aw_have = 1'b1;
			n.awaddr = awaddr;
		end
		if (w_hs)
		begin
			n.w_have = 1'b1;
			n.wdata = wdata;
			n.wstrb = wstrb;
		end
		do_wr = r.aw_have && r.w_have && !r.bvalid;
		if (do_wr)
		begin
			n.aw_have = 1'b0;
			n.w_have = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			unique case (reg_sel(r.awaddr))
				REG_TX:
					if (r.wstrb[0])
					begin
						n.txd = r.wdata[7:0]; // see R16
						n.tx_pend = 1'b1;
						n.tx_occ = 1'b1; // see R13
						n.uflow = start && !r.tx_pend; // see R11
					end
				REG_DIV:
					if (r.wstrb[0])
						n.div = r.wdata[7:0]; // see R14
				REG_CTL:
				begin
					if (r.wstrb[0])
						n.ctrl[7:0] = r.wdata[7:0] & CTL_MASK[7:0];
					if (r.wstrb[1])
						n.ctrl[15:8] = r.wdata[15:8] & CTL_MASK[15:8];
				end
				REG_STA, REG_RX, REG_NONE: n.bresp = RESP_SLVERR;
			endcase
		end
		else if (r.bvalid && bready)
			n.bvalid = 1'b0;

		n.rx_irq = n.rx_full || n.ovf; // see R9
		n.tx_irq = n.ctrl[CTL_EN] && (!n.tx_occ || n.uflow); // see R12
	end

	// The clock enable freezes every flop.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			r <= STATE_RST;
		else if (ce)
			r <= n;
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_tx_occ;
		ce && do_wr && reg_sel(r.awaddr) == REG_TX && r.wstrb[0] &&
			!(start && !r.tx_pend) |=> r.tx_occ && r.tx_pend && !r.uflow;
	endproperty
	a_tx_occ: assert property (p_tx_occ) // see R13
		else $error("transmit write did not mark occupied");
	property p_tx_irq_clr;
		ce && do_wr && reg_sel(r.awaddr) == REG_TX && r.wstrb[0] &&
			!(start && !r.tx_pend) |=> !r.tx_irq;
	endproperty
	a_tx_irq_clr: assert property (p_tx_irq_clr) // see R12
		else $error("transmit interrupt bit not cleared by write");
	property p_rx_clr;
		ce && rd_rx && !done |=> !r.rx_full && !r.ovf && !r.rx_irq;
	endproperty
	a_rx_clr: assert property (p_rx_clr) // see R10
		else $error("receive read left flags set");
	property p_rx_irq;
		r.rx_irq == (r.rx_full || r.ovf);
	endproperty
	a_rx_irq: assert property (p_rx_irq) // see R9
		else $error("receive interrupt bit disagrees with flags");
	property p_ovf_keep;
		ce && done && r.rx_full && !rd_rx && !r.ctrl[CTL_OVW]
			|=> r.ovf && $stable(r.rx);
	endproperty
	a_ovf_keep: assert property (p_ovf_keep) // see R19
		else $error("overflow byte not discarded");
	property p_idle_clk;
		r.st == SMSP_IDLE |-> pin_out.sclk_o == cpol;
	endproperty
	a_idle_clk: assert property (p_idle_clk) // see R4
		else $error("idle serial clock not at polarity");
	property p_disable;
		ce && !en |=> r.st == SMSP_IDLE ##1 r.st == SMSP_IDLE || en;
	endproperty
	a_disable: assert property (p_disable) // see R7
		else $error("disabled port left running");
	property p_drive;
		pin_out.sclk_oe_n == !(en && master) &&
			(pin_out.mosi_oe_n || pin_out.miso_oe_n);
	endproperty
	a_drive: assert property (p_drive) // see R6
		else $error("wrong pin drive for role");
	property p_txmode_start;
		ce && en && master && r.ctrl[CTL_TXMODE] && r.st == SMSP_IDLE &&
			r.tx_pend |=> r.st == SMSP_RUN && !r.tx_pend;
	endproperty
	a_txmode_start: assert property (p_txmode_start) // see R1
		else $error("transmit write did not start a master byte");
	property p_rxmode_start;
		ce && en && master && !r.ctrl[CTL_TXMODE] && r.st == SMSP_IDLE &&
			rd_rx |=> r.st == SMSP_RUN;
	endproperty
	a_rxmode_start: assert property (p_rxmode_start) // see R2
		else $error("receive read did not start a master byte");
	property p_first_bit;
		ce && start && r.tx_pend && !cpha
			|=> r.outb == (lsbf ? $past(r.txd[0]) : $past(r.txd[7]));
	endproperty
	a_first_bit: assert property (p_first_bit) // see R3
		else $error("first bit out has wrong order");
	property p_uflow_zero;
		ce && start && !r.tx_pend && !r.ctrl[CTL_UFMODE] && !cpha
			|=> r.uflow && r.sh == 8'h00 && !r.outb;
	endproperty
	a_uflow_zero: assert property (p_uflow_zero) // see R20
		else $error("underflow did not send zero");

	c_master_byte: cover property (ce && done && master);
	c_slave_byte: cover property (ce && done && !master);
	c_overflow: cover property (ce && done && r.rx_full && !rd_rx);
	c_underflow: cover property (ce && start && !r.tx_pend);

endmodule : smsp_port

/* verification/smsp_far_slave.sv */
`timescale 1ns/1ps
// Far-end slave: samples on one clock edge and changes data on the other.
module smsp_far_slave (
	input wire logic sclk,
	input wire logic mosi,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic lsbf,
	input wire logic arm,
	input wire logic [7:0] tx,
	output logic miso,
	output logic [7:0] rx
);
	int k = 0;
	logic [2:0] idx;
	logic samp;
	// Sampling edge is leading for phase 0 and trailing for phase 1.
	assign samp = sclk ^ cpol ^ cpha;
	assign idx = 3'(lsbf ? k - cpha : 7 - k + cpha);
	// Outside a frame the line shows the inverse, so stale data never matches.
	assign miso = arm ? tx[idx] : ~tx[idx];
	// Shift in on the sampling edge.
	always @(posedge samp)
		if (arm)
			rx <= lsbf ? {mosi, rx[7:1]} : {rx[6:0], mosi};
	// Count changing edges; a dropped arm restarts the byte.
	always @(negedge samp or negedge arm)
		if (!arm)
			k <= 0;
		else
			k <= k + 1;
endmodule : smsp_far_slave

/* verification/spi_master_slave_port_tb.sv */
`timescale 1ns/1ps
module spi_master_slave_port_tb;
	import smsp_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, quiet = 1'b0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
	logic awready, wready, bvalid, arready, rvalid, spi_irq;
	logic [1:0] bresp, rresp;
	logic [4:0] hs;
	logic [31:0] rdata, got, seed = 32'h00012473;
	smsp_pin_in_t pin_in;
	smsp_pin_out_t pin_out;
	logic tsclk = 1'b0, tmosi = 1'b0, tss = 1'b1, arm = 1'b0, psclk = 1'b0;
	logic sclk_ln, mosi_ln, miso_ln, fmiso;
	logic [7:0] ftx = '0, run = '0, frx, d, f, g, sm, half;
	logic [15:0] c, ctl = '0;
	logic [33:0] exp_q[$];
	logic [31:0] ra [6] = '{ADDR_STATUS, ADDR_RX, ADDR_TX, ADDR_DIV,
		ADDR_CTRL, 32'hFFFF0A14};
	logic [33:0] re [6] = '{34'h0, 34'h0, 34'h0, 34'h1B, 34'h0, 34'h200000000};
	int i, failures = 0, comparisons = 0;

	always #25 aclk = ~aclk;
	// Each shared line carries whichever end has its driver enabled.
	assign sclk_ln = pin_out.sclk_oe_n ? tsclk : pin_out.sclk_o;
	assign mosi_ln = pin_out.mosi_oe_n ? tmosi : pin_out.mosi_o;
	assign miso_ln = pin_out.miso_oe_n ? fmiso : pin_out.miso_o;
	assign pin_in = '{sclk: sclk_ln, mosi: mosi_ln, miso: miso_ln, ss_n: tss};
	assign hs = {rvalid, bvalid, arready, wready, awready};

	smsp_port i_smsp_port (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(1'b1), .pin_in(pin_in), .pin_out(pin_out),
		.spi_irq(spi_irq));
	smsp_far_slave i_smsp_far_slave (.sclk(sclk_ln), .mosi(mosi_ln),
		.cpol(ctl[CTL_CPOL]), .cpha(ctl[CTL_CPHA]), .lsbf(ctl[CTL_LSBF]),
		.arm(arm), .tx(ftx), .miso(fmiso), .rx(frx));

	task automatic summarize;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	task automatic over;
		failures++;
		summarize();
	endtask : over

	task automatic cmp(input logic [33:0] gv, input logic [33:0] ev);
		comparisons++;
		if (gv !== ev)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, gv, ev);
		end
	endtask : cmp

	// Repeatable pseudo-random stimulus from a shift register.
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Returns at the edge where handshake bit w is sampled high.
	task automatic await(input int w);
		int n;
		#1;
		for (n = 0; hs[w] !== 1'b1; n++)
		begin
			if (n > 4000)
				over();
			@(posedge aclk);
			#1;
		end
		@(posedge aclk);
	endtask : await

	task automatic wr(input logic [31:0] a, input logic [31:0] v,
		input logic [1:0] r);
		exp_q.push_back({r, 32'h0});
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// Address and data may be taken in either order.
		fork
			begin
				await(0);
				awvalid <= 1'b0;
			end
			begin
				await(1);
				wvalid <= 1'b0;
			end
		join
		await(3);
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [33:0] e,
		input logic q);
		// Updated after the edge so the monitor still sees the last read's mode.
		quiet <= q;
		if (!q)
			exp_q.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		await(2);
		arvalid <= 1'b0;
		await(4);
		got = rdata;
	endtask : rd

	// Each bus answer is matched against the oldest expectation noted.
	always @(posedge aclk)
		if (bvalid || (rvalid && !quiet))
			cmp(bvalid ? {bresp, 32'h0} : {rresp, rdata}, exp_q.pop_front());

	// Half period of the generated clock, in core cycles.
	always @(posedge aclk)
	begin
		psclk <= pin_out.sclk_o;
		run <= (pin_out.sclk_o != psclk) ? 8'h01 : run + 8'h01;
		if (pin_out.sclk_o != psclk)
			half <= run;
	end

	task automatic poll(input int b);
		int n;
		got = '0;
		for (n = 0; n < 400 && got[b] !== 1'b1; n++)
			rd(ADDR_STATUS, '0, 1'b1);
		if (got[b] !== 1'b1)
			over();
	endtask : poll

	// One master byte: configure, queue a byte, wait for a status flag.
	task automatic mx(input logic [15:0] cw, input logic [7:0] dv,
		input int b);
		seed = lfsr(seed);
		d = seed[7:0];
		f = seed[15:8];
		arm <= 1'b0;
		wr(ADDR_DIV, {24'h0, dv}, RESP_OKAY);
		wr(ADDR_CTRL, {16'h0, cw}, RESP_OKAY);
		ctl = cw;
		cmp(pin_out.sclk_o, cw[CTL_CPOL]);
		ftx <= f;
		arm <= 1'b1;
		wr(ADDR_TX, {24'h0, d}, RESP_OKAY);
		if (b == 3)
			rd(ADDR_STATUS, 34'h01, 1'b0);
		poll(b);
		cmp(frx, d);
		cmp(half, dv + 8'h01);
	endtask : mx

	// Outside master sends one byte to the port as slave, mode 0.
	task automatic sx(input logic [7:0] m);
		int k;
		tss <= 1'b0;
		for (k = 7; k >= 0; k--)
		begin
			tmosi <= m[k];
			repeat (8) @(posedge aclk);
			tsclk <= 1'b1;
			sm[k] = miso_ln;
			repeat (8) @(posedge aclk);
			tsclk <= 1'b0;
		end
		repeat (8) @(posedge aclk);
		tss <= 1'b1;
		tmosi <= ~m[0];
	endtask : sx

	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// Reset values, an unmapped place and refused writes.
		for (i = 0; i < 6; i++)
			rd(ra[i], re[i], 1'b0);
		wr(ADDR_STATUS, 32'hFF, RESP_SLVERR);
		wr(ADDR_RX, 32'hFF, RESP_SLVERR);
		cmp(pin_out.sclk_oe_n, 1'b1);
		// Every phase, polarity and bit order; divider 3 for MSB first, 4 for LSB first.
		for (i = 0; i < 8; i++)
		begin
			c = 16'h0043 | 16'({i[2], 1'b0, i[1], i[0], 2'h0});
			mx(c, 8'(3 + i[2]), 3);
			rd(ADDR_STATUS, 34'h1A, 1'b0);
			cmp(spi_irq, 1'b1);
			rd(ADDR_RX, {26'h0, f}, 1'b0);
			rd(ADDR_STATUS, 34'h02, 1'b0);
		end
		wr(ADDR_CTRL, 32'h0, RESP_OKAY);
		rd(ADDR_STATUS, 34'h0, 1'b0);
		// A second byte over unread data is dropped, then overwrites.
		for (i = 0; i < 2; i++)
		begin
			c = i ? 16'h0143 : 16'h0043;
			mx(c, 8'h03, 3);
			g = f;
			mx(c, 8'h03, 5);
			rd(ADDR_STATUS, 34'h3A, 1'b0);
			g = i ? f : g;
			rd(ADDR_RX, {26'h0, g}, 1'b0);
		end
		// Receive reads start bytes with nothing queued to send.
		for (i = 0; i < 2; i++)
		begin
			seed = lfsr(seed);
			c = i ? 16'h0003 : 16'h0083;
			arm <= 1'b0;
			wr(ADDR_CTRL, {16'h0, c}, RESP_OKAY);
			ctl = c;
			ftx <= seed[7:0];
			arm <= 1'b1;
			rd(ADDR_RX, {26'h0, g}, 1'b0);
			poll(3);
			g = seed[7:0];
			cmp(frx, i ? 8'h00 : d);
			rd(ADDR_STATUS, 34'h1E, 1'b0);
			cmp(spi_irq, 1'b1);
		end
		wr(ADDR_TX, 32'h0, RESP_OKAY);
		rd(ADDR_STATUS, 34'h19, 1'b0);
		wr(ADDR_CTRL, 32'h0, RESP_OKAY);
		cmp({pin_out.sclk_oe_n, pin_out.mosi_oe_n, pin_out.sclk_o},
			3'b110);
		// Slave role: an outside master frames one byte.
		wr(ADDR_CTRL, 32'h1, RESP_OKAY);
		cmp(pin_out.sclk_oe_n, 1'b1);
		rd(ADDR_RX, {26'h0, g}, 1'b0);
		seed = lfsr(seed);
		wr(ADDR_TX, {24'h0, seed[7:0]}, RESP_OKAY);
		sx(seed[15:8]);
		poll(3);
		rd(ADDR_RX, {26'h0, seed[15:8]}, 1'b0);
		cmp(sm, seed[7:0]);
		summarize();
	end
endmodule : spi_master_slave_port_tb
